// ==== rtl/amp_control_register_bank.sv ====
// Purpose: Configuration registers of the boosted class D amplifier, with serial slave.
// Assumes: i_clk at 20 MHz, far above the 400 kHz serial clock; pins are asynchronous.
// Notes:   Data pin is open drain; o_sda is always low and o_sda_oe pulls the line.
`timescale 1ns/1ns

// Overview of operation
// RULE1: Offset zero always reads the identity value
// RULE2: Writing 0xaa to offset zero restores defaults
// RULE3: Host leaves offsets above 0x0a and reserved alone
// RULE4: Unmapped offsets read undefined; here they read zero
// RULE5: Answer address 10110 plus two strapped bits
// RULE6: Software enable low shuts the amplifier down
// RULE7: Bit 6 enables charge pump, default one
// RULE8: Bits 5, 4 enable boost and output stage
// RULE9: Bit 3 picks receiver combo mode; 2:0 zero
// RULE10: Safeguard bits 4:3 pick battery threshold, default 01
// RULE11: Safeguard bit 2 enables protection, default zero
// RULE12: Force boost low forces protection enable to zero
// RULE13: Safeguard bits 1:0 pick output ceiling, default 01
// RULE14: Force boost selects forced boost or pass-through
// RULE15: Register pointer advances after each acknowledged byte
// RULE16: Host writes address, one offset byte, then data
// RULE17: Reset restores every default and idles the bus
// RULE18: Reserved bits keep defaults and ignore writes
module amp_control_register_bank
   import amp_regs_pkg::*;
#(
   parameter logic [7:0]   IDENTITY_VALUE = 8'h3c   // Arbitrary value
)
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // Serial bus pins
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,
   // Address select strap
   input  wire logic       i_addr_strap,
   // Power control
   output logic            o_software_enable,
   output logic            o_charge_pump_enable,
   output logic            o_boost_enable,
   output logic            o_output_stage_enable,
   output logic            o_receiver_combo_mode,
   // Battery safeguard
   output logic [1:0]      o_battery_trigger_threshold,
   output logic            o_battery_protect_enable,
   output logic [1:0]      o_protected_output_ceiling,
   // Boost and gain
   output logic            o_force_boost,
   output logic [4:0]      o_step_up_voltage_select,
   output logic [2:0]      o_step_up_current_limit,
   output logic [4:0]      o_output_gain_select,
   // Limiters
   output logic            o_limiter3_disable,
   output logic [3:0]      o_limiter3_power,
   output logic [2:0]      o_limiter3_release_time,
   output logic [2:0]      o_limiter3_attack_time,
   output logic [3:0]      o_limiter2_power,
   output logic [2:0]      o_limiter2_attack_time,
   output logic [1:0]      o_limiter1_attack_time,
   output logic            o_limiter1_disable
);

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } slave_state_e;

   slave_state_e state_reg;
   slave_state_e state_next;
   logic [3:0]   cnt_reg;
   logic [3:0]   cnt_next;
   logic [7:0]   shift_reg;
   logic [7:0]   shift_next;
   logic [7:0]   ptr_reg;
   logic [7:0]   ptr_next;
   logic         drive_reg;
   logic         drive_next;
   logic         rw_reg;
   logic         rw_next;
   logic         mack_reg;
   logic         mack_next;
   logic         wr_en;
   logic [7:0]   cfg_reg  [1:NUM_REGS-1];
   logic [7:0]   cfg_next [1:NUM_REGS-1];
   logic [2:0]   power_reg;
   logic         scl_meta;
   logic         scl_s;
   logic         scl_d;
   logic         sda_meta;
   logic         sda_s;
   logic         sda_d;
   logic         strap_meta;
   logic         strap_s;
   logic [1:0]   a2a1;

   // Pins pass two flops before any logic sees them
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         {scl_meta, scl_s, scl_d}  <= 3'h7;
         {sda_meta, sda_s, sda_d}  <= 3'h7;
         {strap_meta, strap_s}     <= 2'h0;
      end
      else
      begin
         {scl_meta, scl_s, scl_d}  <= {i_scl, scl_meta, scl_s};
         {sda_meta, sda_s, sda_d}  <= {i_sda, sda_meta, sda_s};
         {strap_meta, strap_s}     <= {i_addr_strap, strap_meta};
      end
   end

   wire scl_rise   = scl_s & ~scl_d;
   wire scl_fall   = ~scl_s & scl_d;
   wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

   strap_decoder u_strap (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_scl      (scl_s),
      .i_sda      (sda_s),
      .i_strap    (strap_s),
      .i_start    (start_cond),
      .i_scl_fall (scl_fall),
      .o_a2a1     (a2a1)
   );

   // Reads past the map return zero rather than test content
   function automatic logic [7:0] read_byte(input logic [7:0] addr);
      if (addr == ADDR_IDENTITY)
         return IDENTITY_VALUE;   // RULE1
      else if (addr <= ADDR_LAST)
         return cfg_reg[addr[3:0]];
      else
         return 8'h00;   // RULE4
   endfunction

   // Writable bits from the host, reserved bits from the default table
   function automatic logic [7:0] merge(input logic [7:0] wdata, input int idx);
      return (wdata & REG_WMASK[idx]) | (REG_DEFAULT[idx] & ~REG_WMASK[idx]);   // RULE18
   endfunction

   wire [7:0] rd_byte    = read_byte(ptr_reg);
   wire       addr_match = (shift_reg[7:1] == {I2C_ADDR_PREFIX, a2a1});   // RULE5
   wire       byte_done  = scl_fall && (cnt_reg == BITS_PER_BYTE);
   wire       soft_reset = wr_en && (ptr_reg == ADDR_IDENTITY)
                           && (shift_reg == SOFT_RESET_CMD);   // RULE2

   // Serial slave: sample on clock rise, change data after clock fall
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      ptr_next   = ptr_reg;
      drive_next = drive_reg;
      rw_next    = rw_reg;
      mack_next  = mack_reg;
      wr_en      = 1'b0;
      if (stop_cond)
      begin
         state_next = ST_IDLE;
         drive_next = 1'b0;
      end
      else if (start_cond)
      begin
         state_next = ST_ADDR;
         cnt_next   = 4'd0;
         drive_next = 1'b0;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE: ;
            ST_ADDR, ST_REG, ST_WDATA:
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s};
                  cnt_next   = cnt_reg + 4'd1;
               end
               else if (byte_done)
               begin
                  cnt_next = 4'd0;
                  if (state_reg == ST_ADDR)
                  begin
                     drive_next = addr_match;
                     rw_next    = shift_reg[0];
                     state_next = addr_match ? ST_ADDR_ACK : ST_IDLE;
                  end
                  else if (state_reg == ST_REG)
                  begin
                     ptr_next   = shift_reg;   // RULE16
                     drive_next = 1'b1;
                     state_next = ST_REG_ACK;
                  end
                  else
                  begin
                     wr_en      = 1'b1;
                     ptr_next   = ptr_reg + 8'h01;   // RULE15
                     drive_next = 1'b1;
                     state_next = ST_WDATA_ACK;
                  end
               end
            ST_ADDR_ACK:
               if (scl_fall)
               begin
                  if (rw_reg)
                  begin
                     shift_next = rd_byte;
                     drive_next = ~rd_byte[7];
                     state_next = ST_RDATA;
                  end
                  else
                  begin
                     drive_next = 1'b0;
                     state_next = ST_REG;   // RULE16
                  end
               end
            ST_REG_ACK, ST_WDATA_ACK:
               if (scl_fall)
               begin
                  drive_next = 1'b0;
                  state_next = ST_WDATA;
               end
            ST_RDATA:
               if (scl_fall)
               begin
                  if (cnt_reg == LAST_TX_BIT)
                  begin
                     cnt_next   = 4'd0;
                     drive_next = 1'b0;
                     state_next = ST_RDATA_ACK;
                  end
                  else
                  begin
                     cnt_next   = cnt_reg + 4'd1;
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_next = ~shift_reg[6];
                  end
               end
            ST_RDATA_ACK:
               if (scl_rise)
               begin
                  mack_next = ~sda_s;
                  if (!sda_s)
                     ptr_next = ptr_reg + 8'h01;   // RULE15
               end
               else if (scl_fall)
               begin
                  // A refused byte ends the read; wait for stop or start
                  shift_next = rd_byte;
                  drive_next = mack_reg & ~rd_byte[7];
                  state_next = mack_reg ? ST_RDATA : ST_IDLE;
               end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_reg <= ST_IDLE;   // RULE17
         cnt_reg   <= 4'd0;
         shift_reg <= 8'h00;
         ptr_reg   <= 8'h00;
         drive_reg <= 1'b0;
         rw_reg    <= 1'b0;
         mack_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg   <= ptr_next;
         drive_reg <= drive_next;
         rw_reg    <= rw_next;
         mack_reg  <= mack_next;
      end
   end

   // Writes above the map are dropped; those offsets hold test controls
   always_comb
   begin
      for (int i = 1; i < NUM_REGS; i++)
      begin
         if (soft_reset)
            cfg_next[i] = REG_DEFAULT[i];   // RULE2
         else if (wr_en && (ptr_reg == 8'(i)))
            cfg_next[i] = merge(shift_reg, i);   // RULE3
         else
            cfg_next[i] = cfg_reg[i];
      end
      // Protection needs boost forced; pass-through clears it
      cfg_next[ADDR_BATTERY_SAFEGUARD][BS_PROTECT_ENABLE] =
         cfg_next[ADDR_BATTERY_SAFEGUARD][BS_PROTECT_ENABLE]
         & cfg_next[ADDR_BOOST_OUTPUT_VOLTAGE][BV_FORCE_BOOST];   // RULE12
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         for (int i = 1; i < NUM_REGS; i++)
            cfg_reg[i] <= REG_DEFAULT[i];   // RULE17
      end
      else
      begin
         for (int i = 1; i < NUM_REGS; i++)
            cfg_reg[i] <= cfg_next[i];
      end
   end

   wire [7:0] sys_ctl = cfg_reg[ADDR_SYSTEM_CONTROL];
   wire [7:0] bat_sfg = cfg_reg[ADDR_BATTERY_SAFEGUARD];
   wire [7:0] bst_out = cfg_reg[ADDR_BOOST_OUTPUT_VOLTAGE];
   wire [7:0] l3_tim  = cfg_reg[ADDR_LIMITER3_TIMING];

   // Software disable overrides every power block
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         power_reg <= 3'h0;
      else
         power_reg <= sys_ctl[SC_CHARGE_PUMP_ENABLE -: 3]
                      & {3{sys_ctl[SC_SOFTWARE_ENABLE]}};   // RULE6 RULE7 RULE8
   end

   assign o_sda                       = 1'b0;
   assign o_sda_oe                    = drive_reg;
   assign o_software_enable           = sys_ctl[SC_SOFTWARE_ENABLE];   // RULE6
   assign o_charge_pump_enable        = power_reg[2];   // RULE7
   assign o_boost_enable              = power_reg[1];   // RULE8
   assign o_output_stage_enable       = power_reg[0];   // RULE8
   assign o_receiver_combo_mode       = sys_ctl[SC_RECEIVER_COMBO_MODE];   // RULE9
   assign o_battery_trigger_threshold = bat_sfg[BS_THRESHOLD_LSB +: 2];   // RULE10
   assign o_battery_protect_enable    = bat_sfg[BS_PROTECT_ENABLE];   // RULE11
   assign o_protected_output_ceiling  = bat_sfg[BS_CEILING_LSB +: 2];   // RULE13
   assign o_force_boost               = bst_out[BV_FORCE_BOOST];   // RULE14
   assign o_step_up_voltage_select    = bst_out[4:0];
   assign o_step_up_current_limit     = cfg_reg[ADDR_BOOST_PEAK_CURRENT][4:2];
   assign o_output_gain_select        = cfg_reg[ADDR_AMPLIFIER_GAIN][4:0];
   assign o_limiter3_disable          = cfg_reg[ADDR_LIMITER3_POWER][4];
   assign o_limiter3_power            = cfg_reg[ADDR_LIMITER3_POWER][3:0];
   assign o_limiter3_release_time     = l3_tim[7:5];
   assign o_limiter3_attack_time      = l3_tim[4:2];
   assign o_limiter2_power            = cfg_reg[ADDR_LIMITER2_POWER][3:0];
   assign o_limiter2_attack_time      = cfg_reg[ADDR_LIMITER2_TIMING][4:2];
   assign o_limiter1_attack_time      = cfg_reg[ADDR_LIMITER1_CONTROL][2:1];
   assign o_limiter1_disable          = cfg_reg[ADDR_LIMITER1_CONTROL][0];

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_soft_write;
      wr_en && (ptr_reg == ADDR_IDENTITY) && (shift_reg == SOFT_RESET_CMD);
   endsequence

   sequence s_addr_hit;
      (state_reg == ST_ADDR) && byte_done && (shift_reg[7:1] == {I2C_ADDR_PREFIX, a2a1});
   endsequence

   property p_identity_read;
      (ptr_reg == ADDR_IDENTITY) |-> (rd_byte == IDENTITY_VALUE);
   endproperty
   a_identity_read: assert property (p_identity_read)   // RULE1
      else $error("Identity offset did not read the identity value");

   property p_soft_reset;
      s_soft_write |=> (sys_ctl == REG_DEFAULT[ADDR_SYSTEM_CONTROL])
                       && (cfg_reg[ADDR_LIMITER1_CONTROL] == REG_DEFAULT[ADDR_LIMITER1_CONTROL]);
   endproperty
   a_soft_reset: assert property (p_soft_reset)   // RULE2
      else $error("Soft reset command did not restore defaults");

   property p_addr_ack;
      s_addr_hit |=> o_sda_oe && (state_reg == ST_ADDR_ACK) ##1 o_sda_oe [*2];
   endproperty
   a_addr_ack: assert property (p_addr_ack)   // RULE5
      else $error("Matching address was not acknowledged");

   property p_shutdown;
      !sys_ctl[SC_SOFTWARE_ENABLE] |=> !(o_charge_pump_enable | o_boost_enable
                                         | o_output_stage_enable);
   endproperty
   a_shutdown: assert property (p_shutdown)   // RULE6
      else $error("Power block enabled while software enable is low");

   property p_charge_pump;
      sys_ctl[SC_SOFTWARE_ENABLE] |=> (o_charge_pump_enable == $past(sys_ctl[SC_CHARGE_PUMP_ENABLE]));
   endproperty
   a_charge_pump: assert property (p_charge_pump)   // RULE7
      else $error("Charge pump enable does not follow its bit");

   property p_boost_stage;
      sys_ctl[SC_SOFTWARE_ENABLE] |=> (o_boost_enable == $past(sys_ctl[SC_BOOST_ENABLE]))
         && (o_output_stage_enable == $past(sys_ctl[SC_OUTPUT_STAGE_ENABLE]));
   endproperty
   a_boost_stage: assert property (p_boost_stage)   // RULE8
      else $error("Boost or output stage enable does not follow its bit");

   property p_sys_reserved;
      sys_ctl[2:0] == 3'h0;
   endproperty
   a_sys_reserved: assert property (p_sys_reserved)   // RULE9
      else $error("Reserved system control bits are not zero");

   property p_protect_clamp;
      !bst_out[BV_FORCE_BOOST] |-> !bat_sfg[BS_PROTECT_ENABLE];
   endproperty
   a_protect_clamp: assert property (p_protect_clamp)   // RULE12
      else $error("Protection enabled without forced boost");

   property p_ptr_advance;
      wr_en |=> (ptr_reg == $past(ptr_reg) + 8'h01);
   endproperty
   a_ptr_advance: assert property (p_ptr_advance)   // RULE15
      else $error("Register pointer did not advance after a write");

   property p_reserved_hold;
      ((l3_tim ^ REG_DEFAULT[ADDR_LIMITER3_TIMING]) & ~REG_WMASK[ADDR_LIMITER3_TIMING]) == 8'h00;
   endproperty
   a_reserved_hold: assert property (p_reserved_hold)   // RULE18
      else $error("Reserved bits changed from their default");

endmodule

// ==== rtl/amp_regs_pkg.sv ====
// Purpose: Shared constants for the amplifier control register bank.
// Assumes: Byte-wide registers at offsets 0x00 to 0x0a behind a two-wire serial slave.
// Notes:   Index 0 of the default and mask tables is unused; offset 0 is the identity.
package amp_regs_pkg;

   localparam int          NUM_REGS                  = 11;

   // Register offsets
   localparam logic [7:0]  ADDR_IDENTITY             = 8'h00;
   localparam logic [7:0]  ADDR_SYSTEM_CONTROL       = 8'h01;
   localparam logic [7:0]  ADDR_BATTERY_SAFEGUARD    = 8'h02;
   localparam logic [7:0]  ADDR_BOOST_OUTPUT_VOLTAGE = 8'h03;
   localparam logic [7:0]  ADDR_BOOST_PEAK_CURRENT   = 8'h04;
   localparam logic [7:0]  ADDR_AMPLIFIER_GAIN       = 8'h05;
   localparam logic [7:0]  ADDR_LIMITER3_POWER       = 8'h06;
   localparam logic [7:0]  ADDR_LIMITER3_TIMING      = 8'h07;
   localparam logic [7:0]  ADDR_LIMITER2_POWER       = 8'h08;
   localparam logic [7:0]  ADDR_LIMITER2_TIMING      = 8'h09;
   localparam logic [7:0]  ADDR_LIMITER1_CONTROL     = 8'h0a;
   localparam logic [7:0]  ADDR_LAST                 = 8'h0a;

   // Values after reset, indexed by offset
   localparam logic [NUM_REGS-1:0][7:0] REG_DEFAULT = {
      8'h4a, 8'h08, 8'h03, 8'h4e, 8'h43, 8'h10, 8'h11, 8'he8, 8'h09, 8'h70, 8'h00};
   // Host-writable bits; all others are reserved and keep their default
   localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {
      8'h07, 8'h1c, 8'h0f, 8'hfc, 8'h1f, 8'h1f, 8'h1c, 8'h3f, 8'h1f, 8'hf8, 8'h00};

   localparam logic [7:0]  SOFT_RESET_CMD            = 8'haa;

   // Field positions
   localparam int          SC_SOFTWARE_ENABLE        = 7;
   localparam int          SC_CHARGE_PUMP_ENABLE     = 6;
   localparam int          SC_BOOST_ENABLE           = 5;
   localparam int          SC_OUTPUT_STAGE_ENABLE    = 4;
   localparam int          SC_RECEIVER_COMBO_MODE    = 3;
   localparam int          BS_THRESHOLD_LSB          = 3;
   localparam int          BS_PROTECT_ENABLE         = 2;
   localparam int          BS_CEILING_LSB            = 0;
   localparam int          BV_FORCE_BOOST            = 5;

   // Serial slave address: five fixed bits then the strapped pair
   localparam logic [4:0]  I2C_ADDR_PREFIX           = 5'b10110;
   localparam logic [1:0]  STRAP_GND                 = 2'b00;
   localparam logic [1:0]  STRAP_SCL                 = 2'b01;
   localparam logic [1:0]  STRAP_SDA                 = 2'b10;
   localparam logic [1:0]  STRAP_VDD                 = 2'b11;

   localparam logic [3:0]  BITS_PER_BYTE             = 4'd8;
   localparam logic [3:0]  LAST_TX_BIT               = 4'd7;

endpackage

// ==== rtl/strap_decoder.sv ====
// Purpose: Works out the two strapped address bits from what the select pin follows.
// Assumes: All inputs already synchronised to i_clk with equal latency.
// Notes:   The pin may be tied to ground, supply, clock line or data line.
`timescale 1ns/1ns
module strap_decoder
   import amp_regs_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // Synchronised bus and strap levels
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic       i_strap,
   // Bus events
   input  wire logic       i_start,
   input  wire logic       i_scl_fall,
   // Decoded address bits
   output logic [1:0]      o_a2a1
);

   logic idle_lvl_reg;
   logic start_lvl_reg;
   logic low_lvl_reg;
   logic armed_reg;

   // Every start gives a moment where clock and data differ with clock high
   wire bus_high = i_scl & i_sda;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         idle_lvl_reg  <= 1'b0;
         start_lvl_reg <= 1'b0;
         low_lvl_reg   <= 1'b0;
         armed_reg     <= 1'b0;
      end
      else
      begin
         if (bus_high)
            idle_lvl_reg <= i_strap;
         if (i_start)
            start_lvl_reg <= i_strap;
         if (i_start)
            armed_reg <= 1'b1;
         else if (i_scl_fall && armed_reg)
         begin
            armed_reg   <= 1'b0;
            low_lvl_reg <= i_strap;
         end
      end
   end

   // Decision is complete well before the eighth address bit is compared
   assign o_a2a1 = !start_lvl_reg ? (idle_lvl_reg ? STRAP_SDA : STRAP_GND)
                                  : (low_lvl_reg  ? STRAP_VDD : STRAP_SCL);

endmodule

// ==== test/amp_i2c_host.sv ====
// Purpose: Two-wire bus host model driving the serial pins of the bank.
// Assumes: The data line has a pull-up; i_sda is the resolved wire level.
// Notes:   Each clock level lasts 26 system clocks, just under 400 kHz.
`timescale 1ns/1ns
module amp_i2c_host
(
   // Clock
   input  wire logic i_clk,
   // Bus
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   localparam int Q = 13;
   initial o_scl = 1'b1;
   initial o_sda = 1'b1;
   task automatic tick();
      repeat (Q) @(posedge i_clk);
   endtask
   // Start or repeated start; leaves the clock low
   task automatic start();
      tick();
      o_sda <= 1'b1;
      tick();
      o_scl <= 1'b1;
      tick();
      o_sda <= 1'b0;
      tick();
      o_scl <= 1'b0;
   endtask
   task automatic stop();
      tick();
      o_sda <= 1'b0;
      tick();
      o_scl <= 1'b1;
      tick();
      o_sda <= 1'b1;
      tick();
   endtask
   // Data changes only mid-low, so no false start or stop is made
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                       output logic ack);
      logic [8:0] w;
      logic [8:0] s;
      w = {d, ack_in};
      for (int i = 8; i >= 0; i--)
      begin
         tick();
         o_sda <= w[i];
         tick();
         o_scl <= 1'b1;
         tick();
         s[i] = i_sda;
         tick();
         o_scl <= 1'b0;
      end
      r = s[8:1];
      ack = s[0];
   endtask
endmodule

// ==== test/amp_control_register_bank_tb_top.sv ====
// Purpose: Self-checking bench for the amplifier control register bank.
// Assumes: Address strap tied to ground, so the bank answers 0x58, except in s_strap.
// Notes:   Host never touches offsets above 0x0a or test space.
`timescale 1ns/1ns
module amp_control_register_bank_tb_top;
   import amp_regs_pkg::*;
   localparam logic [7:0] ID  = 8'h3c;   // Arbitrary value
   localparam logic [7:0] DEV = {I2C_ADDR_PREFIX, STRAP_GND, 1'b0};
   logic       i_clk    = 1'b0;
   logic       i_resetn = 1'b0;
   logic       sw, cp, bst, pa, rcv, pe, fb, l3d, l1d;
   logic [1:0] thr, ceil, l1a;
   logic [1:0] tie = STRAP_GND;
   logic [2:0] ilim, l3r, l3a, l2a;
   logic [3:0] l3p, l2p;
   logic [4:0] vsel, gain;
   wire        scl, host_sda, sda_oe, sda_val;
   wire        sda_line = host_sda & (~sda_oe | sda_val);
   // The select pin follows whatever it is strapped to
   wire        strap_pin = (tie == STRAP_VDD) | ((tie == STRAP_SCL) & scl)
                           | ((tie == STRAP_SDA) & sda_line);
   wire [7:0]  pwr = {sw, cp, bst, pa, rcv, 3'h0};
   wire [7:0]  safe = {3'h0, thr, pe, ceil};
   int         mismatches = 0;
   int         checked = 0;
   always #25 i_clk = ~i_clk;
   amp_i2c_host H (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));
   amp_control_register_bank #(.IDENTITY_VALUE(ID)) DUT (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_val),
      .o_sda_oe(sda_oe), .i_addr_strap(strap_pin), .o_software_enable(sw),
      .o_charge_pump_enable(cp), .o_boost_enable(bst), .o_output_stage_enable(pa),
      .o_receiver_combo_mode(rcv), .o_battery_trigger_threshold(thr),
      .o_battery_protect_enable(pe), .o_protected_output_ceiling(ceil), .o_force_boost(fb),
      .o_step_up_voltage_select(vsel), .o_step_up_current_limit(ilim),
      .o_output_gain_select(gain), .o_limiter3_disable(l3d), .o_limiter3_power(l3p),
      .o_limiter3_release_time(l3r), .o_limiter3_attack_time(l3a), .o_limiter2_power(l2p),
      .o_limiter2_attack_time(l2a), .o_limiter1_attack_time(l1a), .o_limiter1_disable(l1d));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Address, one offset byte, data, stop; every byte must be acked
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      logic [7:0] r;
      logic       a0, a1, a2;
      H.start();
      H.xfer(DEV, 1'b1, r, a0);
      H.xfer(off, 1'b1, r, a1);
      H.xfer(d, 1'b1, r, a2);
      H.stop();
      check("write acks", {5'h0, a0, a1, a2}, 8'h00);
   endtask
   // Pointer set once, then a burst; the last byte is not acked
   task automatic rd(input logic [7:0] off, input logic [7:0] exp[$]);
      logic [7:0] r;
      logic       a;
      H.start();
      H.xfer(DEV, 1'b1, r, a);
      H.xfer(off, 1'b1, r, a);
      H.start();
      H.xfer(DEV | 8'h01, 1'b1, r, a);
      foreach (exp[i])
      begin
         H.xfer(8'hff, i == exp.size() - 1, r, a);
         check("read data", r, exp[i]);
      end
      H.stop();
   endtask
   task automatic s_reset();
      check("power", pwr, 8'h00);
      check("safeguard", safe, 8'h09);
      check("boost fields", {2'h3, fb, vsel}, 8'he8);
      check("peak current", {3'h0, ilim, 2'h1}, 8'h11);
      check("gain", {3'h0, gain}, 8'h10);
      check("limiter3 power", {3'h2, l3d, l3p}, 8'h43);
      check("limiter3 timing", {l3r, l3a, 2'h2}, 8'h4e);
      check("limiter2", {1'b0, l2a, l2p}, 8'h23);
      check("limiter1", {5'h09, l1a, l1d}, 8'h4a);
      // Burst stops at the last visible offset; test space is never touched
      rd(8'h00, '{ID, 8'h70, 8'h09, 8'he8, 8'h11, 8'h10, 8'h43, 8'h4e, 8'h03, 8'h08, 8'h4a});
   endtask
   task automatic s_sysctl();
      wr(8'h01, 8'hdf);
      rd(8'h01, '{8'hd8});
      check("power on", pwr, 8'hd8);
      wr(8'h01, 8'h78);
      check("software off", pwr, 8'h08);
   endtask
   task automatic s_guard();
      wr(8'h02, 8'hfe);
      check("safeguard set", safe, 8'h1e);
      wr(8'h03, 8'h08);
      check("pass through", safe, 8'h1a);
      check("force boost", {7'h0, fb}, 8'h00);
      wr(8'h02, 8'h04);
      rd(8'h02, '{8'h00});
   endtask
   task automatic s_soft();
      logic [7:0] r;
      logic       a;
      wr(8'h00, 8'h55);
      rd(8'h00, '{ID});
      wr(8'h00, 8'haa);
      rd(8'h01, '{8'h70, 8'h09, 8'he8});
      check("power after reload", pwr, 8'h00);
      H.start();
      H.xfer({I2C_ADDR_PREFIX, STRAP_VDD, 1'b0}, 1'b1, r, a);
      H.stop();
      check("foreign address ack", {7'h0, a}, 8'h01);
   endtask
   // Each strap choice must make the bank answer its own address
   task automatic s_strap();
      logic [7:0] r;
      logic       a;
      for (int t = 0; t < 4; t++)
      begin
         tie <= 2'(t);
         H.start();
         H.xfer({I2C_ADDR_PREFIX, 2'(t), 1'b0}, 1'b1, r, a);
         H.stop();
         check("strapped address ack", {7'h0, a}, 8'h00);
      end
      tie <= STRAP_GND;
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // About 30k clocks of traffic are expected
   initial
   begin
      repeat (80000) @(posedge i_clk);
      mismatches++;
      give_verdict();
   end
   initial
   begin
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (4) @(posedge i_clk);
      s_reset();
      s_sysctl();
      s_guard();
      s_soft();
      s_strap();
      give_verdict();
   end
endmodule
